// [addr_store.sv]
`timescale 1ns/10ps
`default_nettype none
// Byte store for one bank of addresses; read data registered
module addr_store (
  input  wire logic       sys_clk_in,
  input  wire logic       clk_en_in,
  input  wire logic       wr_en_in,
  input  wire logic [5:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [5:0] rd_idx_in,
  output var  logic [7:0] rd_data_out
);
  logic [7:0] mem [0:63];
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      if (wr_en_in) begin
        mem[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_idx_in];
    end
  end
endmodule : addr_store
`default_nettype wire

// [mgmt_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mgmt_ctrl_model (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  input  wire logic       stall_in,
  input  wire logic       out_valid_in,
  input  wire logic [7:0] out_data_in,
  input  wire logic       out_last_in,
  output var  logic       out_ready_out
);
  logic [7:0] got[$];
  int         last_at = -1;
  int         pseed   = 32'h6cea;
  // Random stalls prove each byte stands until taken
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_ready_out <= 1'h0;
    end else if (clk_en_in) begin
      if (out_valid_in && out_ready_out) begin
        if (out_last_in) last_at = got.size();
        got.push_back(out_data_in);
      end
      out_ready_out <= stall_in ? 1'($random(pseed)) : 1'h1;
    end
  end
endmodule : mgmt_ctrl_model
`default_nettype wire

// [part_cfg_framer.sv]
// Operation
// RL1 - On an error-free query, stream the per-partition response payload
// RL2 - Flag bit 0 shows host driver presence; code forces it zero unless drv_report_sup_in is set
// RL3 - Flag bit 1 set when driver presence reporting is supported
// RL4 - Flag bits 3:2 give link state: down, forced up, follows channel
// RL5 - Flag bit 4 set when link state reporting is supported
// RL6 - Flag bit 5 shows partition configured for boot
// RL7 - Flag bit 6 shows partition supports boot and reporting
// RL8 - Maximum transmit share byte, percent of port speed, 0 to 100
// RL9 - Committed transmit share, 0 to 100; port total must be 100
// RL10 - Report device, vendor, subsystem and subsystem vendor identifiers
// RL11 - Endpoint field names the controller endpoint of the partition
// RL12 - Bus field carries the assigned primary bus number
// RL13 - Device field all ones in ARI mode, else assigned device number
// RL14 - Device FE marks unassigned routing; bus, device, function ignored
// RL15 - Device 00 to 1f keeps function within 00 to 07
// RL16 - Address count equals number of address entries that follow
// RL17 - Permanent entries typed 01 to 08 always all reported
// RL18 - In-use addresses reported with types F1 to F8
// RL19 - Type low nibble 1 to 8 names the address kind in order
// RL20 - Entry type in low byte, length in next byte
// RL21 - Entry carries exactly as many address bytes as its length
// RL22 - Flag bits 7 to 31 are driven zero
// RL23 - Never report link encoding 11; zero when unsupported
`timescale 1ns/10ps
`default_nettype none
module part_cfg_framer (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  input  wire logic        query_in,
  input  wire logic        query_err_in,
  input  wire logic        out_ready_in,
  input  wire logic        host_drv_present_in,
  input  wire logic        drv_report_sup_in,
  input  wire logic [1:0]  link_state_in,
  input  wire logic        link_report_sup_in,
  input  wire logic        boot_cfg_in,
  input  wire logic        bootable_in,
  input  wire logic [7:0]  max_transmit_share_in,
  input  wire logic [7:0]  committed_transmit_share_in,
  input  wire logic [15:0] function_device_identifier_in,
  input  wire logic [15:0] function_vendor_identifier_in,
  input  wire logic [15:0] subsystem_identifier_in,
  input  wire logic [15:0] subsystem_vendor_identifier_in,
  input  wire logic [7:0]  endpoint_in,
  input  wire logic [7:0]  bus_num_in,
  input  wire logic [7:0]  dev_num_in,
  input  wire logic [7:0]  func_num_in,
  input  wire logic        ari_mode_in,
  input  wire logic        routing_assigned_in,
  input  wire logic [7:0]  inuse_valid_in,
  input  wire logic [3:0]  addr_len_in,
  input  wire logic        addr_wr_in,
  input  wire logic        addr_wr_inuse_in,
  input  wire logic [5:0]  addr_wr_idx_in,
  input  wire logic [7:0]  addr_wr_data_in,
  output logic             busy_out,
  output logic             out_valid_out,
  output logic [7:0]       out_data_out,
  output logic             out_last_out
);
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [5:0] ONE6 = 6'h01;
  part_cfg_pkg::frame_state_e st_reg, st_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic [3:0]  ent_reg, ent_next;
  logic [3:0]  byt_reg, byt_next;
  logic [7:0]  data_reg, data_next;
  logic        last_reg, last_next;
  logic        valid_reg, valid_next;
  logic [7:0]  inuse_snap_reg;
  wire  logic        step      = !valid_reg || out_ready_in;
  wire  logic        start     = (st_reg == part_cfg_pkg::ST_IDLE) && query_in && !query_err_in; // see RL1
  wire  logic [1:0]  link_rep  = (link_report_sup_in && link_state_in != part_cfg_pkg::LINK_RESERVED) ?
                                 link_state_in : part_cfg_pkg::LINK_DOWN; // see RL4 see RL23
  wire  logic [31:0] flags     = {25'h0000000, bootable_in, boot_cfg_in, link_report_sup_in, link_rep,
                                  drv_report_sup_in, drv_report_sup_in & host_drv_present_in}; // see RL2
  // Bit order above follows FLAG_DRV through FLAG_BOOTABLE, upper bits zero; see RL3 see RL5 see RL6 see RL7 see RL22
  wire  logic [7:0]  max_sh    = (max_transmit_share_in > part_cfg_pkg::SHARE_MAX) ?
                                 part_cfg_pkg::SHARE_MAX : max_transmit_share_in; // see RL8
  // Summing to 100 across partitions is the configuring party's job; only clamp here
  wire  logic [7:0]  min_sh    = (committed_transmit_share_in > part_cfg_pkg::SHARE_MAX) ?
                                 part_cfg_pkg::SHARE_MAX : committed_transmit_share_in; // see RL9
  wire  logic [7:0]  dev_rep   = !routing_assigned_in ? part_cfg_pkg::DEV_UNASSIGNED :
                                 ari_mode_in ? part_cfg_pkg::DEV_ARI : dev_num_in; // see RL13 see RL14
  wire  logic        legacy    = dev_rep <= part_cfg_pkg::DEV_LEGACY_MAX;
  wire  logic [7:0]  func_rep  = (legacy && func_num_in > part_cfg_pkg::FUNC_LEGACY_MAX) ?
                                 (func_num_in & part_cfg_pkg::FUNC_LEGACY_MAX) : func_num_in; // see RL15
  // Counted from the snapshot so the count matches the entries sent even if the input moves
  wire  logic [3:0]  n_inuse   = 4'(inuse_snap_reg[0]) + 4'(inuse_snap_reg[1]) + 4'(inuse_snap_reg[2]) +
                                 4'(inuse_snap_reg[3]) + 4'(inuse_snap_reg[4]) + 4'(inuse_snap_reg[5]) +
                                 4'(inuse_snap_reg[6]) + 4'(inuse_snap_reg[7]);
  wire  logic [7:0]  addr_cnt  = 8'(part_cfg_pkg::ADDR_TYPES) + {4'h0, n_inuse}; // see RL16
  // Fixed payload in wire order, byte 0 first (flags low byte first)
  wire  logic [191:0] fixed    = {flags[7:0], flags[15:8], flags[23:16], flags[31:24],
                                  8'h00, 8'h00, min_sh, max_sh,
                                  function_vendor_identifier_in[7:0], function_vendor_identifier_in[15:8],
                                  function_device_identifier_in[7:0], function_device_identifier_in[15:8],
                                  subsystem_vendor_identifier_in[7:0], subsystem_vendor_identifier_in[15:8],
                                  subsystem_identifier_in[7:0], subsystem_identifier_in[15:8],
                                  func_rep, dev_rep, bus_num_in, endpoint_in,
                                  addr_cnt, 8'h00, 8'h00, 8'h00}; // see RL10 see RL11 see RL12
  wire  logic [7:0]  fixed_byte = fixed[8'(191 - 8 * int'(cnt_reg)) -: 8];
  // Second pass covers the in-use bank; entries of absent in-use addresses are skipped
  wire  logic        pass2     = ent_reg[3];
  wire  logic [2:0]  ent_idx   = ent_reg[2:0];
  wire  logic        ent_live  = !pass2 || inuse_snap_reg[ent_idx];
  wire  logic [7:0]  ent_type  = (pass2 ? part_cfg_pkg::INUSE_TYPE_BASE : part_cfg_pkg::PERM_TYPE_BASE) +
                                 {5'h00, ent_idx} + 8'h01; // see RL17 see RL18 see RL19
  wire  logic [3:0]  len_eff   = (addr_len_in > 4'(part_cfg_pkg::ADDR_MAX_BYTES)) ?
                                 4'(part_cfg_pkg::ADDR_MAX_BYTES) : addr_len_in;
  wire  logic [5:0]  rd_idx    = {ent_idx, byt_next[2:0]};
  wire  logic [7:0]  perm_q, inuse_q;
  wire  logic [7:0]  addr_byte = pass2 ? inuse_q : perm_q;
  wire  logic        last_ent  = (ent_reg == 4'hf);

  addr_store u_perm (
    .sys_clk_in  (sys_clk_in),
    .clk_en_in   (clk_en_in),
    .wr_en_in    (addr_wr_in && !addr_wr_inuse_in),
    .wr_idx_in   (addr_wr_idx_in),
    .wr_data_in  (addr_wr_data_in),
    .rd_idx_in   (rd_idx),
    .rd_data_out (perm_q)
  );
  addr_store u_inuse (
    .sys_clk_in  (sys_clk_in),
    .clk_en_in   (clk_en_in),
    .wr_en_in    (addr_wr_in && addr_wr_inuse_in),
    .wr_idx_in   (addr_wr_idx_in),
    .wr_data_in  (addr_wr_data_in),
    .rd_idx_in   (rd_idx),
    .rd_data_out (inuse_q)
  );

  // Store read is registered, so it is addressed with the next byte index
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    ent_next   = ent_reg;
    byt_next   = byt_reg;
    data_next  = data_reg;
    last_next  = last_reg && valid_reg && !out_ready_in;
    valid_next = valid_reg && !out_ready_in;
    if (step) begin
      unique case (st_reg)
        part_cfg_pkg::ST_IDLE: begin
          if (start) begin
            st_next  = part_cfg_pkg::ST_FIXED;
            cnt_next = 6'h00;
          end
        end
        part_cfg_pkg::ST_FIXED: begin
          data_next  = fixed_byte;
          valid_next = 1'b1;
          cnt_next   = cnt_reg + ONE6;
          if (cnt_reg == part_cfg_pkg::FIXED_BYTES - ONE6) begin
            st_next  = part_cfg_pkg::ST_TYPE;
            ent_next = 4'h0;
          end
        end
        part_cfg_pkg::ST_TYPE: begin
          if (ent_live) begin
            data_next  = ent_type; // see RL20
            valid_next = 1'b1;
            byt_next   = 4'h0;
            st_next    = part_cfg_pkg::ST_LEN;
          end else if (last_ent) begin
            st_next = part_cfg_pkg::ST_IDLE;
          end else begin
            ent_next = ent_reg + ONE4;
          end
        end
        part_cfg_pkg::ST_LEN: begin
          data_next  = {4'h0, len_eff}; // see RL20
          valid_next = 1'b1;
          last_next  = last_ent && (len_eff == 4'h0); // see RL21
          st_next    = part_cfg_pkg::ST_ADDR;
        end
        part_cfg_pkg::ST_ADDR: begin
          if (byt_reg == len_eff) begin
            if (last_ent) begin
              st_next = part_cfg_pkg::ST_IDLE;
            end else begin
              ent_next = ent_reg + ONE4;
              st_next  = part_cfg_pkg::ST_TYPE;
            end
          end else begin
            data_next  = addr_byte; // see RL21
            valid_next = 1'b1;
            byt_next   = byt_reg + ONE4;
            last_next  = last_ent && (byt_reg + ONE4 == len_eff); // see RL21
          end
        end
        default: st_next = part_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg         <= part_cfg_pkg::ST_IDLE;
      cnt_reg        <= 6'h00;
      ent_reg        <= 4'h0;
      byt_reg        <= 4'h0;
      data_reg       <= 8'h00;
      last_reg       <= 1'b0;
      valid_reg      <= 1'b0;
      inuse_snap_reg <= 8'h00;
    end else if (clk_en_in) begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      ent_reg   <= ent_next;
      byt_reg   <= byt_next;
      data_reg  <= data_next;
      last_reg  <= last_next;
      valid_reg <= valid_next;
      if (start) begin
        inuse_snap_reg <= inuse_valid_in;
      end
    end
  end

  assign busy_out      = st_reg != part_cfg_pkg::ST_IDLE;
  assign out_valid_out = valid_reg;
  assign out_data_out  = data_reg;
  assign out_last_out  = valid_reg && last_reg;

  AST_LINK_NOT_RES: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL23
    !link_report_sup_in |-> flags[3:2] == 2'h0)
    else $error("Link bits set without support");
  AST_LINK_ENC: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL4
    flags[3:2] != part_cfg_pkg::LINK_RESERVED)
    else $error("Reserved link encoding reported");
  AST_DRV_GATED: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL2
    flags[0] |-> flags[1])
    else $error("Driver bit without reporting support");
  AST_DRV_REP: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL3
    flags[1] == drv_report_sup_in)
    else $error("Driver reporting bit wrong");
  AST_LINK_REP: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL5
    flags[4] == link_report_sup_in)
    else $error("Link reporting bit wrong");
  AST_BOOT_BIT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL6
    flags[5] == boot_cfg_in)
    else $error("Boot configured bit wrong");
  AST_BOOTABLE_BIT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL7
    flags[6] == bootable_in)
    else $error("Bootable bit wrong");
  AST_RSV_ZERO: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL22
    flags[31:7] == 25'h0)
    else $error("Reserved flag bits nonzero");
  AST_SHARE_MAX: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL8
    max_sh <= 8'h64 && min_sh <= 8'h64)
    else $error("Share above 100");
  AST_MAX_PASS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL8
    max_transmit_share_in <= part_cfg_pkg::SHARE_MAX |-> max_sh == max_transmit_share_in)
    else $error("Maximum share altered");
  AST_MIN_PASS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL9
    committed_transmit_share_in <= part_cfg_pkg::SHARE_MAX |-> min_sh == committed_transmit_share_in)
    else $error("Committed share altered");
  AST_ARI_DEV: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL13
    (ari_mode_in && routing_assigned_in) |-> dev_rep == 8'hff)
    else $error("ARI device not all ones");
  AST_DEV_PASS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL13
    (routing_assigned_in && !ari_mode_in) |-> dev_rep == dev_num_in)
    else $error("Device number altered");
  AST_UNASSIGNED: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL14
    !routing_assigned_in |-> dev_rep == part_cfg_pkg::DEV_UNASSIGNED)
    else $error("Unassigned routing not marked");
  AST_FUNC_RANGE: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL15
    dev_rep <= 8'h1f |-> func_rep <= 8'h07)
    else $error("Function out of range");
  AST_FUNC_PASS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL15
    dev_rep > part_cfg_pkg::DEV_LEGACY_MAX |-> func_rep == func_num_in)
    else $error("Function number altered");
  AST_START_OUT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL1
    (clk_en_in && start) ##1 (clk_en_in && !valid_reg) |=> out_valid_out && out_data_out == $past(fixed_byte))
    else $error("Response did not start");
  AST_STAND: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL1
    (out_valid_out && !out_ready_in) |=> out_valid_out && $stable(out_data_out))
    else $error("Byte dropped before taken");
  AST_ERR_REFUSED: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL1
    (!busy_out && query_err_in) |=> !busy_out)
    else $error("Errored query started a response");
  AST_LEN_FOLLOWS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL20
    (clk_en_in && step && st_reg == part_cfg_pkg::ST_LEN) |=> out_data_out[7:4] == 4'h0 && out_valid_out)
    else $error("Length byte malformed");
  AST_TYPE_PERM: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL17
    (clk_en_in && step && st_reg == part_cfg_pkg::ST_TYPE && ent_live && !pass2) |=>
    out_valid_out && out_data_out >= 8'h01 && out_data_out <= 8'h08)
    else $error("Permanent entry type out of range");
  AST_TYPE_INUSE: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL18
    (clk_en_in && step && st_reg == part_cfg_pkg::ST_TYPE && ent_live && pass2) |=>
    out_valid_out && out_data_out >= 8'hf1 && out_data_out <= 8'hf8)
    else $error("In-use entry type out of range");
  AST_ADDR_LEN: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL21
    st_reg == part_cfg_pkg::ST_ADDR |-> byt_reg <= len_eff)
    else $error("Address bytes beyond length");
  AST_LAST_END: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL21
    out_last_out |-> st_reg == part_cfg_pkg::ST_ADDR && last_ent && byt_reg == len_eff)
    else $error("Last marker before final byte");
  AST_COUNT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL16
    addr_cnt >= 8'h08 && addr_cnt <= 8'h10)
    else $error("Address count out of range");
  AST_CNT_MATCH: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL16
    busy_out |-> addr_cnt == 8'(part_cfg_pkg::ADDR_TYPES + $countones(inuse_snap_reg)))
    else $error("Address count differs from entries");
endmodule : part_cfg_framer
`default_nettype wire

// [part_cfg_pkg.sv]
package part_cfg_pkg;
  localparam int unsigned ADDR_TYPES      = 8;
  localparam int unsigned ADDR_MAX_BYTES  = 8;
  localparam logic [3:0]  ADDR_LEN_W      = 4'h4;
  localparam logic [7:0]  PERM_TYPE_BASE  = 8'h00;
  localparam logic [7:0]  INUSE_TYPE_BASE = 8'hf0;
  localparam logic [7:0]  SHARE_MAX       = 8'h64;
  localparam logic [7:0]  DEV_ARI         = 8'hff;
  localparam logic [7:0]  DEV_UNASSIGNED  = 8'hfe;
  localparam logic [7:0]  DEV_LEGACY_MAX  = 8'h1f;
  localparam logic [7:0]  FUNC_LEGACY_MAX = 8'h07;
  localparam logic [1:0]  LINK_DOWN       = 2'h0;
  localparam logic [1:0]  LINK_FORCED_UP  = 2'h1;
  localparam logic [1:0]  LINK_FOLLOW     = 2'h2;
  localparam logic [1:0]  LINK_RESERVED   = 2'h3;
  localparam int unsigned FLAG_DRV        = 0;
  localparam int unsigned FLAG_DRV_REP    = 1;
  localparam int unsigned FLAG_LINK_LO    = 2;
  localparam int unsigned FLAG_LINK_HI    = 3;
  localparam int unsigned FLAG_LINK_REP   = 4;
  localparam int unsigned FLAG_BOOT       = 5;
  localparam int unsigned FLAG_BOOTABLE   = 6;
  // Byte length of the fixed payload, counted from the flags word
  localparam logic [5:0]  FIXED_BYTES     = 6'h18;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FIXED = 3'b001,
    ST_TYPE  = 3'b010,
    ST_LEN   = 3'b011,
    ST_ADDR  = 3'b100
  } frame_state_e;
endpackage : part_cfg_pkg

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef logic [7:0] byte_q_t[$];
  logic clk = 1'h0, rst = 1'h1, clk_en = 1'h1, query = 1'h0, qerr = 1'h0, stall = 1'h0;
  logic host = 1'h0, dsup = 1'h0, boot = 1'h0, bootable = 1'h0, lsup = 1'h0, ari = 1'h0, rassign = 1'h1;
  logic wr = 1'h0, wr_inuse = 1'h0, busy, valid, last, ready;
  logic [1:0] link = 2'h0;
  logic [3:0] alen = 4'h0;
  logic [5:0] wr_idx = 6'h00;
  logic [7:0] maxs = 8'h00, mins = 8'h00, ep = 8'h00, bus = 8'h00, dev = 8'h00, fn = 8'h00;
  logic [7:0] inuse = 8'h00, wr_data = 8'h00, data;
  logic [15:0] did = 16'h0000, vid = 16'h0000, ssid = 16'h0000, svid = 16'h0000;
  logic [7:0] mem [128];
  int seed = 32'h6cea, error_cnt = 0, compares = 0;
  always #5 clk = ~clk;
  part_cfg_framer u_part_cfg_framer (.sys_clk_in(clk), .reset_in(rst), .clk_en_in(clk_en),
    .query_in(query), .query_err_in(qerr), .out_ready_in(ready), .host_drv_present_in(host),
    .drv_report_sup_in(dsup), .link_state_in(link), .link_report_sup_in(lsup), .boot_cfg_in(boot),
    .bootable_in(bootable), .max_transmit_share_in(maxs), .committed_transmit_share_in(mins),
    .function_device_identifier_in(did), .function_vendor_identifier_in(vid), .subsystem_identifier_in(ssid),
    .subsystem_vendor_identifier_in(svid), .endpoint_in(ep), .bus_num_in(bus), .dev_num_in(dev),
    .func_num_in(fn), .ari_mode_in(ari), .routing_assigned_in(rassign), .inuse_valid_in(inuse),
    .addr_len_in(alen), .addr_wr_in(wr), .addr_wr_inuse_in(wr_inuse), .addr_wr_idx_in(wr_idx),
    .addr_wr_data_in(wr_data), .busy_out(busy), .out_valid_out(valid), .out_data_out(data), .out_last_out(last));
  mgmt_ctrl_model u_mgmt_ctrl_model (.sys_clk_in(clk), .reset_in(rst), .clk_en_in(clk_en), .stall_in(stall),
    .out_valid_in(valid), .out_data_in(data), .out_last_in(last), .out_ready_out(ready));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v > part_cfg_pkg::SHARE_MAX) ? part_cfg_pkg::SHARE_MAX : v;
  endfunction : clamp
  function automatic byte_q_t build();
    byte_q_t e;
    logic [7:0] d, f, l;
    l = (alen > 4'h8) ? 8'h08 : {4'h0, alen};
    d = ari ? part_cfg_pkg::DEV_ARI : (rassign ? dev : part_cfg_pkg::DEV_UNASSIGNED);
    f = (d <= part_cfg_pkg::DEV_LEGACY_MAX) ? (fn & part_cfg_pkg::FUNC_LEGACY_MAX) : fn;
    e = '{{1'h0, bootable, boot, lsup, (lsup && link != 2'h3) ? link : 2'h0, dsup, host}, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00, clamp(mins), clamp(maxs), vid[7:0], vid[15:8], did[7:0], did[15:8], svid[7:0], svid[15:8],
          ssid[7:0], ssid[15:8], f, d, bus, ep, 8'(8 + $countones(inuse)), 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 16; k++) begin
      if (k < 8 || inuse[k-8]) begin
        e.push_back(k < 8 ? 8'(part_cfg_pkg::PERM_TYPE_BASE + k + 1) : 8'(part_cfg_pkg::INUSE_TYPE_BASE + k - 7));
        e.push_back(l);
        for (int b = 0; b < l; b++) e.push_back(mem[k*8+b]);
      end
    end
    return e;
  endfunction : build
  task automatic rnd_cfg();
    logic [31:0] r;
    @(posedge clk);
    r = $random(seed);
    host <= r[0] & r[1];
    dsup <= r[1];
    boot <= r[2];
    bootable <= r[3];
    lsup <= r[4];
    ari <= r[5];
    rassign <= r[6] | r[5];
    link <= r[8:7];
    alen <= r[12:9];
    inuse <= r[20:13];
    {did, vid} <= $random(seed);
    {ssid, svid} <= $random(seed);
    {maxs, mins, ep, bus} <= $random(seed);
    {dev, fn} <= 16'($random(seed));
  endtask : rnd_cfg
  task automatic corner(input int i);
    @(posedge clk);
    case (i)
      0: begin
        {link, lsup, maxs, mins, dev, fn, ari, rassign, inuse, alen} <= {2'h3, 1'h1, 32'h64651fff, 2'h1, 12'h000};
      end
      1: {ari, rassign, mins, inuse, alen, lsup} <= {2'h3, 16'hffff, 4'h8, 1'h0};
      default: {ari, rassign, alen, inuse, dev, fn} <= {2'h0, 4'hf, 24'h8020ff};
    endcase
  endtask : corner
  task automatic run();
    byte_q_t e;
    int n;
    @(posedge clk);
    e = build();
    u_mgmt_ctrl_model.got.delete();
    u_mgmt_ctrl_model.last_at = -1;
    query <= 1'h1;
    @(posedge clk) query <= 1'h0;
    repeat (3) @(posedge clk);
    query <= 1'h1;
    @(posedge clk) query <= 1'h0;
    n = 0;
    while ((busy !== 1'h0 || valid !== 1'h0) && n < 3000) begin
      clk_en <= !stall || (3'($random(seed)) != 3'h0);
      @(posedge clk);
      n++;
    end
    clk_en <= 1'h1;
    repeat (4) @(posedge clk);
    chk("busy after stream", 1'h0, busy);
    chk("byte count", e.size(), u_mgmt_ctrl_model.got.size());
    foreach (e[i]) chk("stream byte", e[i], u_mgmt_ctrl_model.got[i]);
    chk("last marker", inuse[7] ? e.size() - 1 : -1, u_mgmt_ctrl_model.last_at);
  endtask : run
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 128; i++) begin
      @(posedge clk);
      mem[i] = 8'($random(seed));
      {wr, wr_inuse, wr_idx, wr_data} <= {1'h1, 7'(i), mem[i]};
    end
    @(posedge clk) wr <= 1'h0;
    @(posedge clk) {qerr, query} <= 2'h3;
    repeat (4) @(posedge clk);
    chk("busy on errored query", 1'h0, busy);
    {qerr, query} <= 2'h0;
    for (int i = 0; i < 24; i++) begin
      rnd_cfg();
      if (i < 3) corner(i);
      stall <= i[0];
      run();
    end
    conclude();
  end
  // Generous bound; a full run needs well under a third of it
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : tb
`default_nettype wire
